// file: verilog/pdc_pkg.sv
// Shared constants and carrier types for the power-down clock controller
package pdc_pkg;

  localparam int PDC_ADDR_W = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] PDC_SYSCTL_IDX = 16'hfff2;
  localparam logic [15:0] PDC_STATUS_IDX = 16'hfff3;
  localparam logic [PDC_ADDR_W-1:0] PDC_SYSCTL_ADDR = {PDC_SYSCTL_IDX, 2'h0};
  localparam logic [PDC_ADDR_W-1:0] PDC_STATUS_ADDR = {PDC_STATUS_IDX, 2'h0};

  localparam logic [7:0] PDC_SYSCTL_RST = 8'h0b;
  localparam int PDC_SOFT_STANDBY_SELECT_BIT = 7;
  localparam int PDC_STS_LSB = 4;
  localparam int PDC_STS_W = 3;
  localparam int PDC_RAM_ENABLE_BIT_BIT = 0;

  localparam int PDC_PRESC_STAGES = 12;
  localparam int PDC_SETTLE_W = 18;
  localparam int PDC_SETTLE_BASE = 8192;
  localparam logic [15:0] PDC_DUTY_MIN_KHZ = 16'h1388;

  typedef enum logic [2:0] {
    PDC_ST_RUN    = 3'b000,
    PDC_ST_SLEEP  = 3'b001,
    PDC_ST_SSTBY  = 3'b010,
    PDC_ST_SETTLE = 3'b011,
    PDC_ST_HSTBY  = 3'b100,
    PDC_ST_RESET  = 3'b101
  } pdc_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PDC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pdc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pdc_apb_rsp_t;

  typedef struct packed {
    logic clk_run;
    logic osc_run;
    logic cpu_halt;
    logic cpu_rst;
    logic dma_halt;
    logic dma_rst;
    logic refresh_halt;
    logic refresh_rst;
    logic refresh_cnt_clr;
    logic periph_halt;
    logic periph_rst;
    logic io_hiz;
  } pdc_gate_t;

endpackage : pdc_pkg

// file: verilog/pdc_prescaler.sv
// Prescaler producing one-cycle ticks at phi/2 up to phi/4096
`timescale 1ns/10ps
`default_nettype none
module pdc_prescaler #(
  parameter int STAGES = pdc_pkg::PDC_PRESC_STAGES
) (
  input wire logic ref_clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic run, // clock running
  output logic [STAGES-1:0] tick // tick[i] pulses once per 2^(i+1) clocks
);
  import pdc_pkg::*;

  logic [STAGES-1:0] cnt_r;
  logic [STAGES-1:0] tick_r;

  // [R1] divide chain
  always_ff @(posedge ref_clk) begin
    if (!nrst || !run) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_tick
      always_ff @(posedge ref_clk) begin
        if (!nrst || !run) begin
          tick_r[gi] <= 1'b0;
        end else begin
          tick_r[gi] <= &cnt_r[gi:0];
        end
      end
    end
  endgenerate

  assign tick = tick_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_PRESC_TOP: assert property ( // [R1]
    tick[STAGES-1] |=> !tick[STAGES-1] [*8]
  ) else $error("slowest tick repeats too soon");

endmodule : pdc_prescaler
`default_nettype wire

// file: verilog/pdc_power_ctrl.sv
// Power-down mode sequencer with settling timer, prescaler and APB registers
// Overview of operation
// [R1] Prescaler gives phi/2 down to phi/4096
// [R2] Duty correction on at 5 MHz up
// [R3] Sleep instruction, select bit 0: sleep
// [R4] Sleep keeps clock, DMA, refresh, peripherals running
// [R5] Enabled interrupt ends sleep, starts handling; the code wakes sleep only on periph_irq or NMI, not on enabled external pins
// [R6] Masked: only non-maskable interrupt wakes sleep
// [R7] Reset low in sleep enters reset
// [R8] Standby pin low in sleep: hardware standby
// [R9] Select bit 1: stop clock, reset DMA, peripherals
// [R10] Refresh halts; counter and top bits reinitialised
// [R11] External interrupt exit waits programmed state count
// [R12] Wait field encodes 8192 to 131072 states
// [R13] Software picks wait of at least 8 ms
// [R14] Select bit stays set; software clears it
// [R15] Hardware standby halts, resets all, ports float
// [R16] Software clears RAM enable before standby pin
// [R17] Only enabled unmasked external interrupt ends standby; the code also wakes on NMI
// [R18] Standby pin rise under reset restarts oscillator
// [R19] Settling counter releases at expiry
// [R20] Standby pin low overrides every other mode
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pdc_power_ctrl #(
  parameter int SETTLE_BASE = pdc_pkg::PDC_SETTLE_BASE
) (
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire pdc_pkg::pdc_apb_req_t apb_req, // APB request
  output pdc_pkg::pdc_apb_rsp_t apb_rsp, // APB response
  input wire logic sleep_exec, // CPU executed sleep instruction, pulse
  input wire logic cpu_int_mask, // CPU masks ordinary interrupts
  input wire logic nmi_req, // non-maskable interrupt request
  input wire logic periph_irq, // peripheral interrupt, already module-enabled
  input wire logic [2:0] ext_irq_req, // external interrupt pins, ext_irq_0 is bit 0
  input wire logic [2:0] ext_irq_en, // external interrupt enable bits
  input wire logic reset_in_n, // reset pin, active low
  input wire logic standby_pin_n, // standby pin, active low
  input wire logic [15:0] osc_khz, // oscillator rate in kHz
  output pdc_pkg::pdc_gate_t gate, // clock and reset gating to the chip
  output logic duty_adjust_en, // duty correction of oscillator on
  output logic int_exc_start, // start interrupt handling, pulse
  output logic reset_exc_start, // start reset handling, pulse
  output logic [pdc_pkg::PDC_PRESC_STAGES-1:0] presc_tick // prescaled ticks
);
  import pdc_pkg::*;

  pdc_state_t state_r, state_nxt;
  logic [7:0] sysctl_r;
  logic [PDC_SETTLE_W-1:0] settle_r, settle_nxt;
  pdc_gate_t gate_r, gate_nxt;
  pdc_apb_rsp_t rsp_r;
  logic duty_r, int_exc_r, reset_exc_r;
  logic sleep_wake, sstby_wake, acc, wr_en;

  // Waiting states for a wait select code; 11x is illegal and treated as 10x
  function automatic logic [PDC_SETTLE_W-1:0] settle_len(input logic [2:0] sel);
    logic [PDC_SETTLE_W-1:0] base;
    base = PDC_SETTLE_W'(SETTLE_BASE);
    unique case (sel)
      3'h0: settle_len = base;
      3'h1: settle_len = base << 1;
      3'h2: settle_len = base << 2;
      3'h3: settle_len = base << 3;
      default: settle_len = base << 4;
    endcase
  endfunction : settle_len

  // Gating for each mode
  function automatic pdc_gate_t gate_of(input pdc_state_t st);
    pdc_gate_t g;
    g = '0;
    g.clk_run = 1'b1;
    g.osc_run = 1'b1;
    unique case (st)
      PDC_ST_RUN: ;
      // [R4] only the CPU stops
      PDC_ST_SLEEP: g.cpu_halt = 1'b1;
      // [R9] [R10] refresh settings kept, counter cleared
      PDC_ST_SSTBY, PDC_ST_SETTLE: begin
        g.clk_run = (st == PDC_ST_SETTLE);
        g.osc_run = (st == PDC_ST_SETTLE);
        g.cpu_halt = 1'b1;
        g.dma_halt = 1'b1;
        g.dma_rst = 1'b1;
        g.refresh_halt = 1'b1;
        g.refresh_cnt_clr = 1'b1;
        g.periph_halt = 1'b1;
        g.periph_rst = 1'b1;
      end
      // [R15] everything reset, ports float
      PDC_ST_HSTBY: begin
        g = '1;
        g.clk_run = 1'b0;
        g.osc_run = 1'b0;
      end
      PDC_ST_RESET: begin
        g = '1;
        g.clk_run = 1'b1;
        g.io_hiz = 1'b0;
      end
      default: g = '1;
    endcase
    return g;
  endfunction : gate_of

  // [R5] [R6] sleep wake condition
  assign sleep_wake = nmi_req | (periph_irq & ~cpu_int_mask);
  // [R17] standby wake from enabled unmasked external pins or NMI
  assign sstby_wake = nmi_req | ((|(ext_irq_req & ext_irq_en)) & ~cpu_int_mask);

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    if (!standby_pin_n) begin
      // [R20] [R8] [R15] standby pin wins
      state_nxt = PDC_ST_HSTBY;
    end else begin
      unique case (state_r)
        PDC_ST_RUN: begin
          if (!reset_in_n) begin
            state_nxt = PDC_ST_RESET;
          end else if (sleep_exec) begin
            // [R3] [R9] select bit picks mode
            state_nxt = sysctl_r[PDC_SOFT_STANDBY_SELECT_BIT] ? PDC_ST_SSTBY : PDC_ST_SLEEP;
          end
        end
        PDC_ST_SLEEP: begin
          // [R7] reset from sleep
          if (!reset_in_n) begin
            state_nxt = PDC_ST_RESET;
          end else if (sleep_wake) begin
            state_nxt = PDC_ST_RUN;
          end
        end
        PDC_ST_SSTBY: begin
          if (!reset_in_n) begin
            state_nxt = PDC_ST_RESET;
          end else if (sstby_wake) begin
            // [R11] [R12] load settling count
            state_nxt = PDC_ST_SETTLE;
            settle_nxt = settle_len(sysctl_r[PDC_STS_LSB +: PDC_STS_W]) - 1'b1;
          end
        end
        PDC_ST_SETTLE: begin
          // [R19] count states, release at expiry
          if (!reset_in_n) begin
            state_nxt = PDC_ST_RESET;
          end else if (settle_r == '0) begin
            state_nxt = PDC_ST_RUN;
          end else begin
            settle_nxt = settle_r - 1'b1;
          end
        end
        PDC_ST_HSTBY: begin
          // [R18] pin high under reset restarts oscillator
          state_nxt = reset_in_n ? PDC_ST_RUN : PDC_ST_RESET;
        end
        PDC_ST_RESET: begin
          if (reset_in_n) begin
            state_nxt = PDC_ST_RUN;
          end
        end
        default: state_nxt = PDC_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r <= PDC_ST_RESET;
      settle_r <= '0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // Gating is registered from the next state so it lines up with state_r
  assign gate_nxt = gate_of(state_nxt);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gate_r <= gate_of(PDC_ST_RESET);
    end else begin
      gate_r <= gate_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      int_exc_r <= 1'b0;
      reset_exc_r <= 1'b0;
    end else begin
      // [R5] handling starts on wake
      int_exc_r <= standby_pin_n && reset_in_n && state_nxt == PDC_ST_RUN &&
                   (state_r == PDC_ST_SLEEP || state_r == PDC_ST_SETTLE);
      reset_exc_r <= state_r == PDC_ST_RESET && state_nxt == PDC_ST_RUN;
    end
  end

  // [R2] duty correction threshold
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      duty_r <= 1'b0;
    end else begin
      duty_r <= osc_khz >= PDC_DUTY_MIN_KHZ;
    end
  end

  // APB slave: access phase lasts two cycles, pready on the second
  assign acc = apb_req.psel && apb_req.penable;
  assign wr_en = acc && rsp_r.pready && apb_req.pwrite &&
                 apb_req.paddr == PDC_SYSCTL_ADDR;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready <= acc && !rsp_r.pready;
      rsp_r.pslverr <= acc && !rsp_r.pready &&
                       apb_req.paddr != PDC_SYSCTL_ADDR && apb_req.paddr != PDC_STATUS_ADDR;
      rsp_r.prdata <= '0;
      if (acc && !rsp_r.pready && !apb_req.pwrite) begin
        if (apb_req.paddr == PDC_SYSCTL_ADDR) begin
          rsp_r.prdata <= {24'h0, sysctl_r};
        end else if (apb_req.paddr == PDC_STATUS_ADDR) begin
          rsp_r.prdata <= {8'h0, settle_r[15:0], 1'b0, settle_r[17:16], 2'h0, state_r};
        end
      end
    end
  end

  // [R14] select bit changes only by software write, reset or hardware standby
  always_ff @(posedge ref_clk) begin
    if (!nrst || state_r == PDC_ST_HSTBY) begin
      sysctl_r <= PDC_SYSCTL_RST;
    end else if (wr_en) begin
      sysctl_r <= apb_req.pwdata[7:0];
    end
  end

  pdc_prescaler #(
    .STAGES(PDC_PRESC_STAGES)
  ) u_presc (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(gate_r.clk_run),
    .tick(presc_tick)
  );

  assign apb_rsp = rsp_r;
  assign gate = gate_r;
  assign duty_adjust_en = duty_r;
  assign int_exc_start = int_exc_r;
  assign reset_exc_start = reset_exc_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_SLEEP_ENTRY: assert property ( // [R3]
    state_r == PDC_ST_RUN && sleep_exec && !sysctl_r[PDC_SOFT_STANDBY_SELECT_BIT] && reset_in_n &&
    standby_pin_n |=> state_r == PDC_ST_SLEEP && gate.cpu_halt
  ) else $error("sleep not entered");

  AST_SLEEP_ACTIVE: assert property ( // [R4]
    state_r == PDC_ST_SLEEP |-> gate.clk_run && !gate.dma_halt && !gate.refresh_halt &&
    !gate.periph_halt
  ) else $error("sleep stopped a running unit");

  AST_SLEEP_WAKE: assert property ( // [R5]
    state_r == PDC_ST_SLEEP && nmi_req && reset_in_n && standby_pin_n
    |=> state_r == PDC_ST_RUN && int_exc_start ##1 !int_exc_start
  ) else $error("sleep wake wrong");

  AST_MASKED_STAY: assert property ( // [R6]
    state_r == PDC_ST_SLEEP && !nmi_req && cpu_int_mask && reset_in_n && standby_pin_n
    |=> state_r == PDC_ST_SLEEP
  ) else $error("masked interrupt woke sleep");

  AST_SLEEP_RESET: assert property ( // [R7]
    state_r == PDC_ST_SLEEP && !reset_in_n && standby_pin_n |=> state_r == PDC_ST_RESET
  ) else $error("reset ignored in sleep");

  AST_HW_STANDBY: assert property ( // [R20]
    !standby_pin_n |=> state_r == PDC_ST_HSTBY && gate.io_hiz && !gate.clk_run &&
    gate.dma_rst && gate.periph_rst && gate.refresh_rst
  ) else $error("hardware standby not forced");

  AST_SW_STANDBY: assert property ( // [R9]
    state_r == PDC_ST_RUN && sleep_exec && sysctl_r[PDC_SOFT_STANDBY_SELECT_BIT] && reset_in_n &&
    standby_pin_n |=> state_r == PDC_ST_SSTBY && !gate.clk_run && gate.dma_rst &&
    gate.periph_rst && gate.refresh_cnt_clr && !gate.refresh_rst
  ) else $error("software standby gating wrong");

  AST_SETTLE_LEN: assert property ( // [R12]
    state_r == PDC_ST_SSTBY && sstby_wake && reset_in_n && standby_pin_n
    |=> settle_r == settle_len($past(sysctl_r[PDC_STS_LSB +: PDC_STS_W])) - 1'b1
  ) else $error("settling count wrong");

  AST_SETTLE_HOLD: assert property ( // [R11]
    state_r == PDC_ST_SETTLE && settle_r != '0 && reset_in_n && standby_pin_n
    |=> state_r == PDC_ST_SETTLE && gate.cpu_halt && gate.periph_halt
  ) else $error("released before settling ended");

  AST_SOFT_STANDBY_SELECT_KEEP: assert property ( // [R14]
    state_r == PDC_ST_SETTLE && settle_r == '0 && reset_in_n && standby_pin_n &&
    sysctl_r[PDC_SOFT_STANDBY_SELECT_BIT] && !wr_en |=> state_r == PDC_ST_RUN && sysctl_r[PDC_SOFT_STANDBY_SELECT_BIT]
  ) else $error("select bit lost on wake");

  AST_HSTBY_EXIT: assert property ( // [R18]
    state_r == PDC_ST_HSTBY && standby_pin_n && !reset_in_n
    |=> state_r == PDC_ST_RESET && gate.osc_run ##1 reset_exc_start == (state_r == PDC_ST_RUN)
  ) else $error("hardware standby exit wrong");

  AST_DUTY: assert property ( // [R2]
    osc_khz >= PDC_DUTY_MIN_KHZ |=> duty_adjust_en
  ) else $error("duty correction off at high rate");

endmodule : pdc_power_ctrl
`default_nettype wire

// file: bench/pdc_cpu_model.sv
// CPU core, interrupt sources and external pins seen by the controller
`timescale 1ns/10ps
`default_nettype none
module pdc_cpu_model (
  input wire logic ref_clk, // system clock
  output logic sleep_exec, // sleep instruction pulse
  output logic cpu_int_mask, // CPU interrupt mask
  output logic nmi_req, // non-maskable request
  output logic periph_irq, // module-enabled interrupt
  output logic [2:0] ext_irq_req, // external interrupt pins
  output logic [2:0] ext_irq_en, // external interrupt enables
  output logic reset_in_n, // reset pin
  output logic standby_pin_n, // standby pin
  output logic [15:0] osc_khz // oscillator rate
);
  initial begin
    sleep_exec = 1'b0;
    cpu_int_mask = 1'b0;
    nmi_req = 1'b0;
    periph_irq = 1'b0;
    ext_irq_req = 3'h0;
    ext_irq_en = 3'h0;
    reset_in_n = 1'b1;
    standby_pin_n = 1'b1;
    osc_khz = 16'h0fa0;
  end
  // One instruction, so the pulse lasts one clock
  task automatic sleep_op();
    @(posedge ref_clk);
    sleep_exec <= 1'b1;
    @(posedge ref_clk);
    sleep_exec <= 1'b0;
  endtask : sleep_op
  task automatic pins(input logic rst_n, input logic standby_pin_n_n);
    @(posedge ref_clk);
    reset_in_n <= rst_n;
    standby_pin_n <= standby_pin_n_n;
  endtask : pins
  task automatic irqs(input logic m, input logic nm, input logic p, input logic [2:0] r,
                      input logic [2:0] en);
    @(posedge ref_clk);
    cpu_int_mask <= m;
    nmi_req <= nm;
    periph_irq <= p;
    ext_irq_req <= r;
    ext_irq_en <= en;
  endtask : irqs
  task automatic osc(input logic [15:0] k);
    @(posedge ref_clk);
    osc_khz <= k;
  endtask : osc
endmodule : pdc_cpu_model
`default_nettype wire

// file: bench/power_down_clock_control_test.sv
// Self-checking bench for the power-down clock controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module power_down_clock_control_test;
  import pdc_pkg::*;
  localparam int BASE = 8;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  pdc_apb_req_t req = '0;
  pdc_apb_rsp_t rsp;
  pdc_gate_t gate;
  logic duty, iexc, rexc, slp, msk, nmi, per, rin_n, stb_n, e;
  logic [PDC_PRESC_STAGES-1:0] tick;
  logic [2:0] ereq, een;
  logic [15:0] khz;
  logic [31:0] q;
  int n_fail = 0;
  int cmp_count = 0;
  int n;
  pdc_cpu_model cpu_u (.ref_clk(ref_clk), .sleep_exec(slp), .cpu_int_mask(msk), .nmi_req(nmi),
    .periph_irq(per), .ext_irq_req(ereq), .ext_irq_en(een), .reset_in_n(rin_n),
    .standby_pin_n(stb_n), .osc_khz(khz));
  pdc_power_ctrl #(.SETTLE_BASE(BASE)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .apb_req(req),
    .apb_rsp(rsp), .sleep_exec(slp), .cpu_int_mask(msk), .nmi_req(nmi), .periph_irq(per),
    .ext_irq_req(ereq), .ext_irq_en(een), .reset_in_n(rin_n), .standby_pin_n(stb_n),
    .osc_khz(khz), .gate(gate), .duty_adjust_en(duty), .int_exc_start(iexc),
    .reset_exc_start(rexc), .presc_tick(tick));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic apb(input logic w, input logic [PDC_ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    `CHK(rsp.pready, 1'b1)
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic chk_state(input pdc_state_t s);
    apb(1'b0, PDC_STATUS_ADDR, 32'h0);
    `CHK(q[2:0], s)
  endtask : chk_state
  task automatic wait_exc(input logic rst);
    int k;
    k = 0;
    while ((rst ? rexc : iexc) !== 1'b1 && k < 300) begin
      step();
      k++;
    end
    `CHK(rst ? rexc : iexc, 1'b1)
  endtask : wait_exc
  task automatic tick_gap(input int i);
    int k;
    k = 0;
    while (tick[i] !== 1'b1 && k < 5000) begin
      step();
      k++;
    end
    n = 0;
    do begin
      step();
      n++;
    end while (tick[i] !== 1'b1 && n < 5000);
  endtask : tick_gap
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, PDC_SYSCTL_ADDR, 32'h0);
    `CHK(q, {24'h0, PDC_SYSCTL_RST})
    apb(1'b0, 18'h00010, 32'h0);
    `CHK(e, 1'b1)
    for (int i = 0; i < 12; i += 11) begin
      tick_gap(i);
      `CHK(n, 2 ** (i + 1))
    end
    cpu_u.osc(16'h1387);
    repeat (2) step();
    `CHK(duty, 1'b0)
    cpu_u.osc(16'h1388);
    repeat (2) step();
    `CHK(duty, 1'b1)
    apb(1'b1, PDC_SYSCTL_ADDR, 32'h0b);
    cpu_u.irqs(1'b1, 1'b0, 1'b1, 3'h0, 3'h0);
    cpu_u.sleep_op();
    repeat (4) step();
    `CHK(gate.cpu_halt, 1'b1)
    `CHK({gate.clk_run, gate.dma_halt, gate.refresh_halt, gate.periph_halt}, 4'h8)
    chk_state(PDC_ST_SLEEP);
    cpu_u.irqs(1'b1, 1'b1, 1'b1, 3'h0, 3'h0);
    wait_exc(1'b0);
    cpu_u.irqs(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    cpu_u.sleep_op();
    cpu_u.irqs(1'b0, 1'b0, 1'b1, 3'h0, 3'h0);
    wait_exc(1'b0);
    chk_state(PDC_ST_RUN);
    cpu_u.irqs(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    cpu_u.sleep_op();
    cpu_u.pins(1'b0, 1'b1);
    chk_state(PDC_ST_RESET);
    cpu_u.pins(1'b1, 1'b1);
    wait_exc(1'b1);
    apb(1'b1, PDC_SYSCTL_ADDR, 32'h0a);
    cpu_u.sleep_op();
    cpu_u.pins(1'b1, 1'b0);
    chk_state(PDC_ST_HSTBY);
    `CHK({gate.clk_run, gate.dma_rst, gate.refresh_rst, gate.periph_rst, gate.io_hiz}, 5'hf)
    `CHK({gate.osc_run, gate.cpu_rst}, 2'h1)
    cpu_u.pins(1'b0, 1'b1);
    chk_state(PDC_ST_RESET);
    `CHK(gate.osc_run, 1'b1)
    cpu_u.pins(1'b1, 1'b1);
    wait_exc(1'b1);
    // bench clock acts as an external clock, so any wait code is legal
    for (int c = 0; c < 7; c++) begin
      apb(1'b1, PDC_SYSCTL_ADDR, {24'h0, 1'b1, 3'(c), 4'hb});
      cpu_u.sleep_op();
      cpu_u.irqs(1'b0, 1'b0, 1'b1, 3'h1, 3'h0);
      repeat (3) step();
      `CHK({gate.clk_run, gate.cpu_halt, gate.dma_rst, gate.periph_rst}, 4'h7)
      `CHK({gate.refresh_halt, gate.refresh_rst, gate.refresh_cnt_clr}, 3'h5)
      cpu_u.irqs(1'b1, 1'b0, 1'b0, 3'h1, 3'h1);
      repeat (3) step();
      `CHK(gate.clk_run, 1'b0)
      cpu_u.irqs(1'b0, 1'b0, 1'b0, 3'h1, 3'h1);
      n = 0;
      while (gate.clk_run !== 1'b1 && n < 20) begin
        step();
        n++;
      end
      n = 0;
      while (iexc !== 1'b1 && n < 300) begin
        step();
        n++;
      end
      `CHK(n, c < 4 ? BASE << c : BASE << 4)
      cpu_u.irqs(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
      apb(1'b0, PDC_SYSCTL_ADDR, 32'h0);
      `CHK(q[7], 1'b1)
    end
    cpu_u.sleep_op();
    cpu_u.irqs(1'b0, 1'b0, 1'b0, 3'h1, 3'h1);
    repeat (4) step();
    cpu_u.pins(1'b1, 1'b0);
    chk_state(PDC_ST_HSTBY);
    cpu_u.pins(1'b0, 1'b1);
    cpu_u.pins(1'b1, 1'b1);
    wait_exc(1'b1);
    apb(1'b0, PDC_SYSCTL_ADDR, 32'h0);
    `CHK(q, {24'h0, PDC_SYSCTL_RST})
    complete_run();
  end
endmodule : power_down_clock_control_test
`default_nettype wire
